// File: src/ivf_fault_resp.sv
`timescale 1ns/100ps
// Operation
// - response 00: output keeps running with no interruption during fault
// - response 01: keep running for delay, then retry setting if fault stays
// - response 10: disable output at once, then follow retry count
// - response 11: disable output and hold it off until fault cleared
// - latch cleared by status bit clear, clear-faults command or reset
// - latch also cleared by host turning output off then on again
// - retry count 000: no restart, output off until cleared
// - retry count 1 to 6: that many restarts, then stay off
// - restart attempts start one delay apart, 2 to the delay field units
// - retry count 111: retry forever until commanded off
// - delay field n means 2 to the n units
// - same delay sets keep-running time after fault detection
// - delay unit comes from the time-unit setting register
// - overvoltage warning threshold stored as 16-bit linear word
// - undervoltage warning threshold stored, also ratio-regulation threshold
// - ratio regulation active only when enabled in vendor options
module ivf_fault_resp #(
  parameter int unsigned TU_100US_CYC =
    ivf_pkg::TU_100US_NS / ivf_pkg::CLK_NS,
  parameter int unsigned TU_1MS_CYC =
    ivf_pkg::TU_1MS_NS / ivf_pkg::CLK_NS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire ivf_pkg::ivf_cmd_t cmd,
  input wire logic ctrl_pin,
  input wire logic vin_ov_fault,
  input wire logic [15:0] vin_meas,
  output logic rd_valid_r,
  output logic [15:0] rd_data_r,
  output logic out_en_r,
  output logic fault_latched_r,
  output logic warn_r,
  output logic ratio_regulation_mode_r
);
  import ivf_pkg::*;

  // linear word to signed fixed point, 16 fraction bits
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
    logic [4:0] sh;
    sh = {~w[15], w[14:11]};
    lin_to_fix = $signed({{37{w[10]}}, w[10:0]}) <<< sh;
  endfunction

  // command code to register memory index
  function automatic logic [2:0] mem_slot(input logic [7:0] c);
    case (c)
      CMD_OV_WARN_THR: mem_slot = {1'b1, MIDX_OVW};
      CMD_UV_WARN_THR: mem_slot = {1'b1, MIDX_UVW};
      CMD_TIME_UNIT: mem_slot = {1'b1, MIDX_TU};
      CMD_VENDOR_OPT: mem_slot = {1'b1, MIDX_OPT};
      default: mem_slot = 3'h0;
    endcase
  endfunction

  logic ctrl_m_r, ctrl_s_r, fault_m_r, fault_s_r;
  logic [7:0] act_r, op_r;
  logic [2:0] status_r, status_nxt;
  ivf_state_t st_r, st_nxt;
  logic [2:0] try_cnt_r, try_cnt_nxt;
  logic [7:0] dly_cnt_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic rd_pend_r;
  logic [7:0] rd_code_r;
  logic [15:0] mem_rd;
  logic [MEM_DEPTH-1:0][15:0] words;
  logic dly_start;

  // pins are asynchronous: two flops before use
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_m_r <= 1'b0;
      ctrl_s_r <= 1'b0;
      fault_m_r <= 1'b0;
      fault_s_r <= 1'b0;
    end else begin
      ctrl_m_r <= ctrl_pin;
      ctrl_s_r <= ctrl_m_r;
      fault_m_r <= vin_ov_fault;
      fault_s_r <= fault_m_r;
    end
  end

  // command decode
  wire [2:0] wr_slot = mem_slot(cmd.code);
  wire [2:0] rd_slot = mem_slot(cmd.code);
  wire wr_op = cmd.wr && cmd.code == CMD_OPERATION;
  wire wr_act = cmd.wr && cmd.code == CMD_OV_FAULT_ACT;
  wire wr_stat = cmd.wr && cmd.code == CMD_STATUS_INPUT;
  wire clr_cmd = cmd.wr && cmd.code == CMD_CLEAR_FAULTS;
  wire on_req = ctrl_s_r && op_r[OP_ON_BIT];
  wire [1:0] resp = act_r[ACT_RESP_HI:ACT_RESP_LO];
  wire [2:0] retry = act_r[ACT_RETRY_HI:ACT_RETRY_LO];
  wire [2:0] dly_sel = act_r[ACT_DELAY_HI:ACT_DELAY_LO];
  wire clr_bit = wr_stat && cmd.wdata[ST_FAULT_BIT];
  wire clr_latch = clr_bit || clr_cmd;
  wire [2:0] rd_code_slot = mem_slot(rd_code_r); // slot of the held read

  // thresholds live in the register memory
  ivf_regmem ivf_regmem_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .wr_en(cmd.wr && wr_slot[2]),
    .wr_idx(wr_slot[1:0]),
    .wr_data(cmd.wdata),
    .rd_idx(rd_slot[1:0]),
    .rd_data(mem_rd),
    .words(words)
  );

  // delay length and unit select
  wire [7:0] dly_last = 8'((9'h001 << dly_sel) - 9'h001);
  wire [1:0] tu_sel = words[MIDX_TU][TU_SEL_HI:0];
  wire [DIV_W-1:0] div_last =
    (tu_sel == 2'h0) ? DIV_W'(TU_1US_CYC - 1) :
    (tu_sel == 2'h1) ? DIV_W'(TU_10US_CYC - 1) :
    (tu_sel == 2'h2) ? DIV_W'(TU_100US_CYC - 1) :
    DIV_W'(TU_1MS_CYC - 1);
  wire unit_tick = div_cnt_r == div_last;
  wire dly_done = unit_tick && dly_cnt_r == dly_last;
  wire timing = st_r == ST_HOLD || st_r == ST_WAIT;

  // divider restarts with each delay so every delay is a whole count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt_r <= '0;
      dly_cnt_r <= 8'h00;
    end else if (dly_start || !timing) begin
      div_cnt_r <= '0;
      dly_cnt_r <= 8'h00;
    end else if (unit_tick) begin
      div_cnt_r <= '0;
      dly_cnt_r <= dly_cnt_r + 8'h01;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_W'(1);
    end
  end

  // fault response sequencer
  always_comb begin
    st_nxt = st_r;
    try_cnt_nxt = try_cnt_r;
    dly_start = 1'b0;
    if (!on_req) begin
      st_nxt = ST_OFF;
      try_cnt_nxt = 3'h0;
    end else begin
      case (st_r)
        ST_OFF: begin
          st_nxt = ST_RUN;
        end
        ST_RUN: begin
          try_cnt_nxt = 3'h0;
          if (fault_s_r) begin
            case (resp)
              RESP_IGNORE: st_nxt = ST_RUN;
              RESP_KEEP_RUN: begin
                st_nxt = ST_HOLD;
                dly_start = 1'b1;
              end
              RESP_OFF_RETRY: begin
                dly_start = 1'b1;
                st_nxt = (retry == RETRY_NONE) ? ST_LATCH : ST_WAIT;
              end
              default: st_nxt = ST_LATCH;
            endcase
          end
        end
        ST_HOLD: begin
          if (dly_done && fault_s_r) begin
            dly_start = 1'b1;
            st_nxt = (retry == RETRY_NONE) ? ST_LATCH : ST_WAIT;
          end else if (dly_done) begin
            st_nxt = ST_RUN;
          end
        end
        ST_WAIT: begin
          if (dly_done) begin
            try_cnt_nxt = (retry == RETRY_FOREVER) ? 3'h0 :
              try_cnt_r + 3'h1;
            if (!fault_s_r) begin
              st_nxt = ST_RUN;
            end else if (retry != RETRY_FOREVER &&
                         try_cnt_r + 3'h1 >= retry) begin
              st_nxt = ST_LATCH;
            end else begin
              dly_start = 1'b1;
            end
          end
        end
        ST_LATCH: begin
          try_cnt_nxt = 3'h0;
          if (clr_latch) begin
            st_nxt = ST_RUN;
          end
        end
        default: st_nxt = ST_OFF;
      endcase
    end
  end

  // warning comparisons in fixed point across exponents
  wire signed [47:0] vin_fix = lin_to_fix(vin_meas);
  wire ov_warn = vin_fix > lin_to_fix(words[MIDX_OVW]);
  wire uv_warn = vin_fix < lin_to_fix(words[MIDX_UVW]);
  wire ratio_on = words[MIDX_OPT][OPT_RATIO_BIT] && uv_warn;

  // sticky status: a new event beats the clear in the same cycle
  always_comb begin
    status_nxt = status_r;
    if (clr_cmd) begin
      status_nxt = 3'h0;
    end else if (wr_stat) begin
      status_nxt = status_r & ~cmd.wdata[2:0];
    end
    status_nxt[ST_FAULT_BIT] = status_nxt[ST_FAULT_BIT] | fault_s_r;
    status_nxt[ST_OVW_BIT] = status_nxt[ST_OVW_BIT] | ov_warn;
    status_nxt[ST_UVW_BIT] = status_nxt[ST_UVW_BIT] | uv_warn;
  end

  // state, control registers and outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_OFF;
      try_cnt_r <= 3'h0;
      act_r <= ACT_RST;
      op_r <= OP_RST;
      status_r <= STATUS_RST;
      out_en_r <= 1'b0;
      fault_latched_r <= 1'b0;
      warn_r <= 1'b0;
      ratio_regulation_mode_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      try_cnt_r <= try_cnt_nxt;
      if (wr_act) act_r <= cmd.wdata[7:0];
      if (wr_op) op_r <= cmd.wdata[7:0];
      status_r <= status_nxt;
      out_en_r <= st_nxt == ST_RUN || st_nxt == ST_HOLD;
      fault_latched_r <= st_nxt == ST_LATCH;
      warn_r <= status_nxt[ST_OVW_BIT] | status_nxt[ST_UVW_BIT];
      ratio_regulation_mode_r <= ratio_on;
    end
  end

  // read: memory word lands a cycle later, then registered out
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_pend_r <= 1'b0;
      rd_code_r <= 8'h00;
      rd_valid_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      rd_pend_r <= cmd.rd;
      rd_code_r <= cmd.code;
      rd_valid_r <= rd_pend_r;
      if (rd_pend_r) begin
        rd_data_r <= (rd_code_r == CMD_OV_FAULT_ACT) ? {8'h00, act_r} :
          (rd_code_r == CMD_OPERATION) ? {8'h00, op_r} :
          (rd_code_r == CMD_STATUS_INPUT) ? {13'h0000, status_r} :
          rd_code_slot[2] ? mem_rd : 16'h0000;
      end
    end
  end

  chk_ignore_runs: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_RUN && on_req && fault_s_r && resp == RESP_IGNORE
    |=> out_en_r && st_r == ST_RUN)
    else $error("ignore response dropped the output");
  chk_hold_runs: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_HOLD |-> out_en_r && !fault_latched_r)
    else $error("output off while keeping on");
  chk_disable_now: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_RUN && on_req && fault_s_r && resp == RESP_OFF_RETRY
    |=> !out_en_r)
    else $error("output not disabled at once");
  chk_latch_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_LATCH |-> !out_en_r && fault_latched_r)
    else $error("latched fault with output on");
  chk_clear_exit: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_LATCH && on_req && clr_latch |=> st_r == ST_RUN)
    else $error("clear did not release latch");
  chk_off_resets: assert property (@(posedge clk_sys) disable iff (!rstn)
    !on_req |=> st_r == ST_OFF && try_cnt_r == 3'h0 && !out_en_r)
    else $error("turn-off did not reset sequencer");
  chk_no_retry: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_RUN && on_req && fault_s_r && resp == RESP_OFF_RETRY &&
    retry == RETRY_NONE |=> st_r == ST_LATCH)
    else $error("zero retry did not latch");
  chk_retry_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_r == ST_WAIT && retry != RETRY_FOREVER |-> try_cnt_r < retry)
    else $error("retry count overran setting");
  chk_unit_spacing: assert property (@(posedge clk_sys)
    disable iff (!rstn) timing |-> dly_cnt_r <= dly_last &&
    div_cnt_r <= div_last)
    else $error("restart spacing overran its delay");
  chk_warn_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    status_r[ST_OVW_BIT] && !wr_stat && !clr_cmd
    |=> status_r[ST_OVW_BIT] [*1])
    else $error("warning flag lost");
endmodule // ivf_fault_resp

// File: src/ivf_pkg.sv
package ivf_pkg;
  // command codes the host reaches this block with
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OV_FAULT_ACT = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_THR = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_THR = 8'h58;
  localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
  localparam logic [7:0] CMD_TIME_UNIT = 8'hC8;
  localparam logic [7:0] CMD_VENDOR_OPT = 8'hE0;

  // fault action fields
  localparam int ACT_RESP_HI = 7;
  localparam int ACT_RESP_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_KEEP_RUN = 2'h1;
  localparam logic [1:0] RESP_OFF_RETRY = 2'h2;
  localparam logic [1:0] RESP_LATCH_OFF = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // other bit positions
  localparam int OP_ON_BIT = 7;
  localparam int ST_FAULT_BIT = 0;
  localparam int ST_OVW_BIT = 1;
  localparam int ST_UVW_BIT = 2;
  localparam int OPT_RATIO_BIT = 0;
  localparam int TU_SEL_HI = 1;

  // values after reset
  localparam logic [7:0] ACT_RST = 8'hC0;
  localparam logic [7:0] OP_RST = 8'h80;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [15:0] OVW_RST = 16'h7BFF;
  localparam logic [15:0] UVW_RST = 16'h0000;
  localparam logic [15:0] TU_RST = 16'h0000;
  localparam logic [15:0] OPT_RST = 16'h0000;

  // register memory layout
  localparam int MEM_DEPTH = 4;
  localparam logic [1:0] MIDX_OVW = 2'h0;
  localparam logic [1:0] MIDX_UVW = 2'h1;
  localparam logic [1:0] MIDX_TU = 2'h2;
  localparam logic [1:0] MIDX_OPT = 2'h3;

  // delay time units
  localparam int CLK_NS = 5;
  localparam int TU_1US_NS = 1000;
  localparam int TU_10US_NS = 10000;
  localparam int TU_100US_NS = 100000;
  localparam int TU_1MS_NS = 1000000;
  localparam int TU_1US_CYC = TU_1US_NS / CLK_NS;
  localparam int TU_10US_CYC = TU_10US_NS / CLK_NS;
  localparam int DIV_W = 18;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } ivf_cmd_t;

  typedef enum {
    ST_OFF,
    ST_RUN,
    ST_HOLD,
    ST_WAIT,
    ST_LATCH
  } ivf_state_t;
endpackage

// File: src/ivf_regmem.sv
`timescale 1ns/100ps
module ivf_regmem (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [ivf_pkg::MEM_DEPTH-1:0][15:0] words
);
  import ivf_pkg::*;

  localparam logic [MEM_DEPTH-1:0][15:0] MEM_RST =
    {OPT_RST, TU_RST, UVW_RST, OVW_RST};

  // words are flops so the comparators can watch them all at once
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      words <= MEM_RST;
      rd_data <= 16'h0000;
    end else begin
      if (wr_en) begin
        words[wr_idx] <= wr_data;
      end
      rd_data <= words[rd_idx];
    end
  end
endmodule // ivf_regmem

// File: verif/ivf_host_model.sv
`timescale 1ns/100ps
module ivf_host_model (
  input wire logic clk_sys,
  input wire logic rd_valid_r,
  input wire logic [15:0] rd_data_r,
  output ivf_pkg::ivf_cmd_t cmd
);
  import ivf_pkg::*;

  initial cmd = '0;

  // one command per call; idle bus shows inverted data, not a stale copy
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_sys);
    cmd <= '{1'b1, 1'b0, c, d};
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b0, ~c, ~d};
  endtask

  // answer pulse stands one cycle, so poll every cycle up to the third
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    d = 'x;
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b1, c, ~cmd.wdata};
    @(negedge clk_sys);
    cmd <= '{1'b0, 1'b0, ~c, cmd.wdata};
    repeat (3) begin
      @(negedge clk_sys);
      if (rd_valid_r === 1'b1)
        d = rd_data_r;
    end
  endtask
endmodule // ivf_host_model

// File: verif/ivf_fault_resp_tb.sv
`timescale 1ns/100ps
module ivf_fault_resp_tb;
  import ivf_pkg::*;
  logic clk_sys, rstn, ctrl_pin, vin_ov_fault;
  logic [15:0] vin_meas, d;
  logic rd_valid_r, out_en_r, fault_latched_r, warn_r, ratio_r;
  logic [15:0] rd_data_r;
  ivf_cmd_t cmd;
  int mismatches = 0;
  int n_compared = 0;
  int k;

  // short time units keep the long retry delays affordable
  ivf_fault_resp #(.TU_100US_CYC(20), .TU_1MS_CYC(40)) ivf_fault_resp_inst (
    .clk_sys(clk_sys), .rstn(rstn), .cmd(cmd), .ctrl_pin(ctrl_pin),
    .vin_ov_fault(vin_ov_fault), .vin_meas(vin_meas),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .out_en_r(out_en_r),
    .fault_latched_r(fault_latched_r), .warn_r(warn_r),
    .ratio_regulation_mode_r(ratio_r));
  ivf_host_model ivf_host_model_inst (.clk_sys(clk_sys),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .cmd(cmd));

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // counts falling edges until the chosen output reaches v
  task automatic wt(input logic lat, input logic v, input int lim);
    for (k = 0; k < lim; k++) begin
      @(negedge clk_sys);
      if ((lat ? fault_latched_r : out_en_r) === v)
        break;
    end
  endtask

  // two cycles early to four cycles late of slack for the input synchroniser
  function automatic int near(input int s, input int e);
    return (s >= e - 2 && s <= e + 4) ? e : s;
  endfunction

  task automatic t_regs();
    logic [7:0] c [7] = '{CMD_OV_WARN_THR, CMD_UV_WARN_THR,
      CMD_OV_FAULT_ACT, CMD_OPERATION, CMD_TIME_UNIT, CMD_VENDOR_OPT, 8'h33};
    logic [15:0] e [7] = '{OVW_RST, UVW_RST, {8'h00, ACT_RST},
      {8'h00, OP_RST}, TU_RST, OPT_RST, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      ivf_host_model_inst.rd(c[i], d);
      check("reset_value", d, e[i]);
    end
    ivf_host_model_inst.wr(CMD_OV_WARN_THR, 16'h1234);
    ivf_host_model_inst.wr(CMD_UV_WARN_THR, 16'habcd);
    ivf_host_model_inst.rd(CMD_OV_WARN_THR, d);
    check("ov_thr", d, 16'h1234);
    ivf_host_model_inst.rd(CMD_UV_WARN_THR, d);
    check("uv_thr", d, 16'habcd);
  endtask

  task automatic t_warn();
    ivf_host_model_inst.wr(CMD_UV_WARN_THR, 16'h0010);
    ivf_host_model_inst.wr(CMD_OV_WARN_THR, 16'h7bff);
    vin_meas = 16'h0008;
    repeat (4) @(negedge clk_sys);
    check("ratio_off", ratio_r, 1'b0);
    check("uv_warn", warn_r, 1'b1);
    ivf_host_model_inst.wr(CMD_VENDOR_OPT, 16'h0001);
    repeat (4) @(negedge clk_sys);
    check("ratio_on", ratio_r, 1'b1);
    vin_meas = 16'h0018;
    ivf_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    repeat (4) @(negedge clk_sys);
    check("no_warn", warn_r, 1'b0);
    ivf_host_model_inst.wr(CMD_OV_WARN_THR, 16'h0014);
    repeat (4) @(negedge clk_sys);
    check("ov_warn", warn_r, 1'b1);
  endtask

  task automatic t_ignore();
    int bad = 0;
    ivf_host_model_inst.wr(CMD_OV_FAULT_ACT, 16'h0000);
    vin_ov_fault = 1'b1;
    repeat (80) begin
      @(negedge clk_sys);
      if (out_en_r !== 1'b1)
        bad++;
    end
    check("ignore_off_cycles", bad, 0);
    vin_ov_fault = 1'b0;
  endtask

  // response 01, no retry, 4 units of 20 cycles
  task automatic t_keep();
    int e;
    ivf_host_model_inst.wr(CMD_TIME_UNIT, 16'h0002);
    ivf_host_model_inst.wr(CMD_OV_FAULT_ACT, 16'h0042);
    vin_ov_fault = 1'b1;
    wt(1'b0, 1'b0, 200);
    check("keep_run_cyc", near(k, 82), 82);
    check("keep_latched", fault_latched_r, 1'b1);
    vin_ov_fault = 1'b0;
    ivf_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
    wt(1'b0, 1'b1, 12);
    // the two short time units, one unit of hold each
    for (int s = 0; s < 2; s++) begin
      e = s ? TU_10US_CYC + 2 : TU_1US_CYC + 2;
      ivf_host_model_inst.wr(CMD_TIME_UNIT, 16'(s));
      ivf_host_model_inst.wr(CMD_OV_FAULT_ACT, 16'h0040);
      vin_ov_fault = 1'b1;
      wt(1'b0, 1'b0, 2100);
      check("keep_unit_cyc", near(k, e), e);
      vin_ov_fault = 1'b0;
      ivf_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt(1'b0, 1'b1, 12);
    end
  endtask

  task automatic t_retry();
    int u;
    for (int r = 0; r < 7; r++) begin
      u = (r % 2) ? 40 : 20;
      ivf_host_model_inst.wr(CMD_TIME_UNIT, 16'(2 + r % 2));
      ivf_host_model_inst.wr(CMD_OV_FAULT_ACT,
        {8'h00, RESP_OFF_RETRY, 3'(r), 3'(r)});
      vin_ov_fault = 1'b1;
      wt(1'b0, 1'b0, 8);
      check("off_at_once", k < 8, 1'b1);
      wt(1'b1, 1'b1, 9000);
      check("latch_cyc", near(k, r * (2 ** r) * u), r * (2 ** r) * u);
      vin_ov_fault = 1'b0;
      ivf_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt(1'b0, 1'b1, 12);
      check("restart_clear", k < 12, 1'b1);
    end
  endtask

  task automatic t_forever();
    ivf_host_model_inst.wr(CMD_TIME_UNIT, 16'h0002);
    ivf_host_model_inst.wr(CMD_OV_FAULT_ACT, {8'h00, RESP_OFF_RETRY, 6'h38});
    vin_ov_fault = 1'b1;
    repeat (300) @(negedge clk_sys);
    check("forever_latch", fault_latched_r, 1'b0);
    check("forever_out", out_en_r, 1'b0);
    vin_ov_fault = 1'b0;
    wt(1'b0, 1'b1, 30);
    check("forever_restart", k < 30, 1'b1);
  endtask

  // each way of clearing a latched fault; reset goes last
  task automatic t_clear();
    ivf_host_model_inst.wr(CMD_OV_FAULT_ACT, {8'h00, RESP_LATCH_OFF, 6'h00});
    for (int m = 0; m < 5; m++) begin
      vin_ov_fault = 1'b1;
      wt(1'b0, 1'b0, 8);
      vin_ov_fault = 1'b0;
      repeat (60) @(negedge clk_sys);
      check("latch_out", out_en_r, 1'b0);
      check("latch_flag", fault_latched_r, 1'b1);
      ivf_host_model_inst.rd(CMD_STATUS_INPUT, d);
      check("status_fault", d[ST_FAULT_BIT], 1'b1);
      case (m)
        0: ivf_host_model_inst.wr(CMD_CLEAR_FAULTS, 16'h0000);
        1: ivf_host_model_inst.wr(CMD_STATUS_INPUT, 16'h0001);
        2: begin
          ctrl_pin = 1'b0;
          repeat (6) @(negedge clk_sys);
          ctrl_pin = 1'b1;
        end
        3: begin
          ivf_host_model_inst.wr(CMD_OPERATION, 16'h0000);
          ivf_host_model_inst.wr(CMD_OPERATION, 16'h0080);
        end
        default: begin
          rstn = 1'b0;
          repeat (2) @(negedge clk_sys);
          rstn = 1'b1;
        end
      endcase
      wt(1'b0, 1'b1, 12);
      check("cleared_on", k < 12, 1'b1);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // whole run is about 20k cycles; give it well over double
  initial begin
    #300000;
    mismatches++;
    test_done();
  end

  initial begin
    rstn = 1'b0;
    ctrl_pin = 1'b1;
    vin_ov_fault = 1'b0;
    vin_meas = 16'h0018;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    wt(1'b0, 1'b1, 10);
    t_regs();
    t_warn();
    t_ignore();
    t_keep();
    t_retry();
    t_forever();
    t_clear();
    test_done();
  end
endmodule // ivf_fault_resp_tb
